// ===== inc/odac_pkg.sv
/*
 * odac_pkg: constants shared by the eight-channel dac update control.
 * assumes a single 100 MHz register clock and apb data of 32 bits.
 */
package odac_pkg;
    localparam int ODAC_CHANNELS = 8;
    localparam int ODAC_CODE_W = 16;
    localparam int ODAC_SHIFT_W = 24;
    localparam int ODAC_ADDR_W = 7;
    // upper five bits of the 7-bit target address (arbitrary value)
    localparam logic [4:0] ODAC_ADDR_HI = 5'h0C;
    localparam logic [15:0] ODAC_ZERO_SCALE = 16'h0000;
    localparam logic [15:0] ODAC_MID_SCALE = 16'h8000;
    // command nibble of the 24-bit word: write input register only
    localparam logic [3:0] ODAC_CMD_WRITE_INPUT = 4'h1;
    // command nibble: write input register and update dac register
    localparam logic [3:0] ODAC_CMD_WRITE_UPDATE = 4'h3;
    // register byte offsets
    localparam logic [11:0] ODAC_OFS_CTRL = 12'h000;
    localparam logic [11:0] ODAC_OFS_STATUS = 12'h004;
    localparam logic [11:0] ODAC_OFS_PENDING = 12'h008;
    localparam logic [11:0] ODAC_OFS_DAC0 = 12'h020;
    localparam logic [11:0] ODAC_OFS_INPUT0 = 12'h040;
    // ctrl fields
    localparam int ODAC_CTRL_SYNC_BIT = 0;
    localparam logic [31:0] ODAC_CTRL_RESET = 32'h0000_0000;
    // status fields
    localparam int ODAC_STAT_RESET_LOW_BIT = 0;
    localparam int ODAC_STAT_BUSY_BIT = 1;
    localparam int ODAC_STAT_LEVEL_BIT = 2;
    typedef enum logic [2:0] {
        ODAC_IDLE = 3'b000,
        ODAC_ADDR = 3'b001,
        ODAC_AACK = 3'b011,
        ODAC_DATA = 3'b010,
        ODAC_DACK = 3'b110,
        ODAC_SKIP = 3'b111
    } odac_state_t;
endpackage : odac_pkg

// ===== hw/odac_ctrl.sv
/*
 * odac_ctrl: two-wire serial slave filling a 24-bit shift register, eight
 * channels of input and dac registers, load strobe and falling-edge reset.
 * assumes all pins are asynchronous to pclk and sampled twice; the serial
 * clock is slow (80 ns or more) so edges are found by oversampling.
 */
// Local design decisions: the register offsets and the APB register port.
// Operation
// - serial clock and data shift a 24-bit input shift register.
// - target address bit 0 follows the first address pin.
// - target address bit 1 follows the second address pin.
// - the data line is only pulled low or released, never driven high.
// - a low pulse on the load strobe copies pending inputs to dac regs.
// - load strobe update works in asynchronous and synchronous modes.
// - a load strobe held permanently low keeps updating in asynchronous mode only.
// - the hardware reset acts on a falling edge of the reset input.
// - while reset input is low, load strobe pulses are ignored.
// - reset loads input and dac registers with the selected level.
// - select low gives zero scale, select high gives midscale.
module odac_ctrl
    import odac_pkg::*;
#(
    parameter int CHANNELS = ODAC_CHANNELS
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic addr_pin_0,
    input wire logic addr_pin_1,
    input wire logic load_strobe_n,
    input wire logic reset_in_n,
    input wire logic reset_level_select,
    output logic [CHANNELS*ODAC_CODE_W-1:0] dac_codes
);
    // channel selects below are three bits wide: only eight channels work
    if (CHANNELS != ODAC_CHANNELS)
    begin : g_bad_channels
        $error("odac_ctrl: channel count must be eight");
    end

    // pin synchronisers: first stage read only by the second
    logic [5:0] sync1_q;
    logic [5:0] sync2_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_q <= 6'h3F;
            sync2_q <= 6'h3F;
        end
        else
        begin
            sync1_q <= {scl_in, sda_in, load_strobe_n, reset_in_n,
                        addr_pin_1, addr_pin_0};
            sync2_q <= sync1_q;
        end
    end
    logic scl_s, sda_s, load_strobe_n_s, rst_s, a1_s, a0_s;
    assign {scl_s, sda_s, load_strobe_n_s, rst_s, a1_s, a0_s} = sync2_q;

    logic [5:0] prev_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prev_q <= 6'h3F;
        else
            prev_q <= sync2_q;
    end
    logic scl_p, sda_p, load_strobe_n_p, rst_p;
    assign scl_p = prev_q[5];
    assign sda_p = prev_q[4];
    assign load_strobe_n_p = prev_q[3];
    assign rst_p = prev_q[2];

    wire scl_rise = scl_s && !scl_p;
    wire scl_fall = !scl_s && scl_p;
    wire start_cond = scl_s && scl_p && sda_p && !sda_s;
    wire stop_cond = scl_s && scl_p && !sda_p && sda_s;
    wire reset_fall = rst_p && !rst_s;
    wire reset_low = !rst_s;

    // target address: high bits fixed, low bits from the pins
    wire [ODAC_ADDR_W-1:0] own_addr =
        {ODAC_ADDR_HI, a1_s, a0_s};

    // serial slave state
    odac_state_t state_q;
    logic [3:0] bitcnt_q;
    logic [1:0] bytecnt_q;
    logic [7:0] byte_q;
    logic [ODAC_SHIFT_W-1:0] shift_q;
    logic word_done_q;
    logic sda_low_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= ODAC_IDLE;
            bitcnt_q <= 4'h0;
            bytecnt_q <= 2'h0;
            byte_q <= 8'h00;
            shift_q <= '0;
            word_done_q <= 1'b0;
            sda_low_q <= 1'b0;
        end
        else
        begin
            word_done_q <= 1'b0;
            if (start_cond)
            begin
                state_q <= ODAC_ADDR;
                bitcnt_q <= 4'h0;
                bytecnt_q <= 2'h0;
                sda_low_q <= 1'b0;
            end
            else if (stop_cond)
            begin
                state_q <= ODAC_IDLE;
                sda_low_q <= 1'b0;
            end
            else
            begin
                case (state_q)
                    ODAC_IDLE:
                        sda_low_q <= 1'b0;
                    ODAC_ADDR, ODAC_DATA:
                    begin
                        if (scl_rise)
                        begin
                            byte_q <= {byte_q[6:0], sda_s};
                            bitcnt_q <= bitcnt_q + 4'h1;
                        end
                        else if (scl_fall && bitcnt_q == 4'h8)
                        begin
                            bitcnt_q <= 4'h0;
                            if (state_q == ODAC_ADDR)
                            begin
                                // writes only; reads are not acknowledged
                                if (byte_q[7:1] == own_addr && !byte_q[0])
                                begin
                                    state_q <= ODAC_AACK;
                                    sda_low_q <= 1'b1;
                                end
                                else
                                    state_q <= ODAC_SKIP;
                            end
                            else
                            begin
                                shift_q <= {shift_q[15:0], byte_q};
                                state_q <= ODAC_DACK;
                                sda_low_q <= 1'b1;
                                if (bytecnt_q == 2'h2)
                                begin
                                    bytecnt_q <= 2'h0;
                                    word_done_q <= 1'b1;
                                end
                                else
                                    bytecnt_q <= bytecnt_q + 2'h1;
                            end
                        end
                    end
                    ODAC_AACK, ODAC_DACK:
                    begin
                        if (scl_fall)
                        begin
                            sda_low_q <= 1'b0;
                            state_q <= ODAC_DATA;
                        end
                    end
                    ODAC_SKIP:
                        sda_low_q <= 1'b0;
                    default:
                    begin
                        state_q <= ODAC_IDLE;
                        sda_low_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // open drain: value is always low, enable low only while pulling
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sda_out <= 1'b0;
            sda_oe_n <= 1'b1;
        end
        else
        begin
            sda_out <= 1'b0;
            sda_oe_n <= !sda_low_q;
        end
    end

    // apb control register
    logic sync_mode_q;
    // write lands once, at the edge that samples pready high
    wire apb_wr = psel && penable && pwrite && pready;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sync_mode_q <= ODAC_CTRL_RESET[ODAC_CTRL_SYNC_BIT];
        else if (apb_wr && paddr == ODAC_OFS_CTRL)
            sync_mode_q <= pwdata[ODAC_CTRL_SYNC_BIT];
    end

    // load strobe: falling edge, or level while held low (async mode)
    wire load_strobe_n_fall = load_strobe_n_p && !load_strobe_n_s;
    wire load_strobe_n_level = !load_strobe_n_s;
    // sync mode: update only on the strobe edge; async: while low too
    wire load_strobe_n_go = !reset_low &&
        (sync_mode_q ? load_strobe_n_fall : load_strobe_n_level);

    // decoded serial word
    wire [3:0] cmd = shift_q[23:20];
    wire [3:0] chan = shift_q[19:16];
    wire [15:0] code = shift_q[15:0];
    wire chan_ok = chan < 4'(CHANNELS);

    function automatic logic [15:0] odac_level(input logic sel);
        odac_level = sel ? ODAC_MID_SCALE : ODAC_ZERO_SCALE;
    endfunction : odac_level

    logic [15:0] input_q [CHANNELS];
    logic [15:0] dac_q [CHANNELS];
    logic [CHANNELS-1:0] pending_q;
    logic level_q;

    // level select strap, two flops like every other pin
    logic [1:0] lvl_sync_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            lvl_sync_q <= 2'h0;
        else
            lvl_sync_q <= {lvl_sync_q[0], reset_level_select};
    end
    wire lvl_s = lvl_sync_q[1];

    // level select caught on the reset falling edge, not at async reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            level_q <= 1'b0;
        else if (reset_fall)
            level_q <= lvl_s;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < CHANNELS; i++)
            begin
                input_q[i] <= ODAC_ZERO_SCALE;
                dac_q[i] <= ODAC_ZERO_SCALE;
            end
            pending_q <= '0;
        end
        else if (reset_fall)
        begin
            // strap must settle before the reset edge; it is seen late
            for (int i = 0; i < CHANNELS; i++)
            begin
                input_q[i] <= odac_level(lvl_s);
                dac_q[i] <= odac_level(lvl_s);
            end
            pending_q <= '0;
        end
        else
        begin
            for (int i = 0; i < CHANNELS; i++)
            begin
                if (load_strobe_n_go && pending_q[i])
                begin
                    dac_q[i] <= input_q[i];
                end
            end
            if (load_strobe_n_go)
                pending_q <= '0;
            if (word_done_q && chan_ok)
            begin
                input_q[chan[2:0]] <= code;
                if (cmd == ODAC_CMD_WRITE_UPDATE)
                    dac_q[chan[2:0]] <= code;
                else if (cmd == ODAC_CMD_WRITE_INPUT)
                    pending_q[chan[2:0]] <= 1'b1; // new data beats clear
            end
        end
    end

    // registered outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dac_codes <= '0;
        else
            for (int i = 0; i < CHANNELS; i++)
                dac_codes[i*ODAC_CODE_W +: ODAC_CODE_W] <= dac_q[i];
    end

    // apb read path: one wait state so prdata is registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && penable && !pready;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && penable && !pready)
            begin
                if (paddr == ODAC_OFS_CTRL)
                    prdata <= {31'h0, sync_mode_q};
                else if (paddr == ODAC_OFS_STATUS)
                    prdata <= {29'h0, level_q, state_q != ODAC_IDLE,
                               reset_low};
                else if (paddr == ODAC_OFS_PENDING)
                    prdata <= {24'h0, pending_q};
                else if (paddr >= ODAC_OFS_DAC0 &&
                         paddr < ODAC_OFS_DAC0 + 12'h020 &&
                         paddr[1:0] == 2'b00)
                    prdata <= {16'h0, dac_q[paddr[4:2]]};
                else if (paddr >= ODAC_OFS_INPUT0 &&
                         paddr < ODAC_OFS_INPUT0 + 12'h020 &&
                         paddr[1:0] == 2'b00)
                    prdata <= {16'h0, input_q[paddr[4:2]]};
                else
                    pslverr <= 1'b1;
            end
        end
    end
endmodule : odac_ctrl

// ===== dv/odac_checker.sv
/* odac_checker: port assertions for odac_ctrl.
   assumes one pclk domain; bound into every odac_ctrl. */
module odac_checker
    import odac_pkg::*;
#(
    parameter int CHANNELS = ODAC_CHANNELS
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sda_out,
    input wire logic load_strobe_n,
    input wire logic reset_in_n,
    input wire logic reset_level_select,
    input wire logic [CHANNELS*ODAC_CODE_W-1:0] dac_codes
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable ##1 psel && penable;
    endsequence
    // level must hold past the sync delay before the codes are judged
    sequence s_rst_fall(lv);
        $fell(reset_in_n) && reset_level_select == lv
            ##1 (!reset_in_n && reset_level_select == lv) [*6];
    endsequence
    a_wait_state: assert property (s_setup |=> pready)
        else $error("pready missing in second access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_data: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response without ready or with data");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside ready cycle");
    a_sda_low_only: assert property (sda_out == 1'b0)
        else $error("data line driven high");
    // a strobe taken would reach the codes about four cycles late
    sequence s_reset_held;
        (!reset_in_n) [*8];
    endsequence
    a_zero_scale: assert property (
        s_rst_fall(1'b0) |-> dac_codes == '0)
        else $error("reset did not load zero scale");
    a_mid_scale: assert property (
        s_rst_fall(1'b1) |-> dac_codes == {CHANNELS{ODAC_MID_SCALE}})
        else $error("reset did not load midscale");
    a_strobe_ignored: assert property (
        s_reset_held ##0 !$past(load_strobe_n, 4) |-> $stable(dac_codes))
        else $error("strobe moved codes while reset low");
endmodule : odac_checker
bind odac_ctrl odac_checker #(.CHANNELS(CHANNELS)) u_chk (
    .pclk, .presetn, .psel, .penable, .prdata, .pready, .pslverr,
    .sda_out, .load_strobe_n, .reset_in_n, .reset_level_select, .dac_codes
);

// ===== dv/odac_host_model.sv
/* odac_host_model: two-wire bus controller sending write frames.
   assumes 100 MHz pclk, scl period of 8 pclk, pull-ups on both lines. */
module odac_host_model
(
    input wire logic pclk,
    input wire logic sda_wire,
    output logic scl,
    output logic sda_pull
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick
    // data moves a cycle after scl falls, so the ack release is never raced
    task automatic bit_io(input logic b, output logic s);
        scl <= 1'b0;
        tick(1);
        sda_pull <= !b;
        tick(3);
        scl <= 1'b1;
        tick(2);
        s = sda_wire;
        tick(2);
    endtask : bit_io
    task automatic frame(input logic [6:0] a, input logic [23:0] w,
        output logic acked);
        logic [31:0] bits;
        logic s;
        bits = {a, 1'b0, w};
        acked = 1'b1;
        sda_pull <= 1'b1;
        tick(4);
        for (int i = 31; i >= 0; i--)
        begin
            bit_io(bits[i], s);
            if (i % 8 == 0)
            begin
                bit_io(1'b1, s);
                acked = acked & !s;
            end
        end
        bit_io(1'b0, s);
        sda_pull <= 1'b0;
        tick(4);
    endtask : frame
endmodule : odac_host_model

// ===== dv/testbench.sv
/* testbench: odac_ctrl against a register-level reference model.
   assumes odac_host_model on the serial pins and the bound checker. */
module testbench
    import odac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin $display( \
    "MISMATCH t=%0t got=%h exp=%h", $time, g, e); mismatches++; end end
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, scl, sda_pull, sda_out, sda_oe_n;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic addr_pin_0 = 1'b0, addr_pin_1 = 1'b0, load_strobe_n = 1'b1;
    logic reset_in_n = 1'b1, reset_level_select = 1'b0, e, ack, sync_m;
    logic [127:0] dac_codes;
    logic [15:0] inp_m [8];
    logic [15:0] dac_m [8];
    logic pend_m [8];
    wire sda_wire = !sda_pull && (sda_oe_n || sda_out);
    odac_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .scl_in(scl), .sda_in(sda_wire),
        .sda_out, .sda_oe_n, .addr_pin_0, .addr_pin_1, .load_strobe_n,
        .reset_in_n, .reset_level_select, .dac_codes);
    odac_host_model host (.pclk, .sda_wire, .scl, .sda_pull);
    initial forever #5 pclk = ~pclk;
    // ceiling: 20000 cycles, about three times 19 frames of 304 cycles plus register reads
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            end_of_test();
        end
    end
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no own limit: only the cycle ceiling ends a hung wait
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic word(input int c, input logic [3:0] cmd,
        input logic [15:0] v);
        host.frame({ODAC_ADDR_HI, addr_pin_1, addr_pin_0},
            {cmd, 4'(c), v}, ack);
        `CHK(ack, 1'b1)
        inp_m[c] = v;
        pend_m[c] = (cmd == ODAC_CMD_WRITE_INPUT);
        if (!pend_m[c] || (!sync_m && !load_strobe_n && reset_in_n))
        begin
            dac_m[c] = v;
            pend_m[c] = 1'b0;
        end
    endtask : word
    task automatic pulse();
        load_strobe_n <= 1'b0;
        repeat (4) @(posedge pclk);
        load_strobe_n <= 1'b1;
        repeat (6) @(posedge pclk);
        for (int c = 0; c < 8; c++)
        begin
            if (pend_m[c] && reset_in_n)
                dac_m[c] = inp_m[c];
            pend_m[c] &= !reset_in_n;
        end
    endtask : pulse
    task automatic check_all();
        for (int c = 0; c < 8; c++)
        begin
            `CHK(dac_codes[16*c +: 16], dac_m[c])
            apb(1'b0, ODAC_OFS_DAC0 + 12'(4 * c), 32'h0);
            `CHK(r[15:0], dac_m[c])
            apb(1'b0, ODAC_OFS_INPUT0 + 12'(4 * c), 32'h0);
            `CHK(r[15:0], inp_m[c])
        end
    endtask : check_all
    task automatic set_all(input logic [15:0] v);
        for (int c = 0; c < 8; c++)
        begin
            inp_m[c] = v;
            dac_m[c] = v;
            pend_m[c] = 1'b0;
        end
    endtask : set_all
    task automatic end_of_test();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test
    initial
    begin
        void'($urandom(69));
        set_all(ODAC_ZERO_SCALE);
        sync_m = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check_all();
        apb(1'b0, ODAC_OFS_CTRL, 32'h0);
        `CHK(r, ODAC_CTRL_RESET)
        apb(1'b0, 12'hFFC, 32'h0);
        `CHK({e, r}, {1'b1, 32'h0})
        $display("test regs done");
        for (int a = 0; a < 4; a++)
        begin
            {addr_pin_1, addr_pin_0} <= 2'(a);
            repeat (4) @(posedge pclk);
            for (int k = 1; k < 3; k++)
            begin
                host.frame({ODAC_ADDR_HI, 2'(a ^ k)}, 24'h1FFFF, ack);
                `CHK(ack, 1'b0)
            end
            word(a, ODAC_CMD_WRITE_UPDATE,
                16'($urandom));
        end
        check_all();
        $display("test address done");
        apb(1'b1, ODAC_OFS_CTRL, 32'h1);
        sync_m = 1'b1;
        // strobe held low in sync mode: new words must wait for an edge
        load_strobe_n <= 1'b0;
        for (int c = 0; c < 8; c += 2)
            word(c, ODAC_CMD_WRITE_INPUT, 16'($urandom));
        check_all();
        load_strobe_n <= 1'b1;
        repeat (4) @(posedge pclk);
        pulse();
        check_all();
        $display("test sync done");
        apb(1'b1, ODAC_OFS_CTRL, 32'h0);
        sync_m = 1'b0;
        load_strobe_n <= 1'b0;
        repeat (8) @(posedge pclk);
        word(3, ODAC_CMD_WRITE_INPUT, 16'($urandom));
        repeat (8) @(posedge pclk);
        check_all();
        load_strobe_n <= 1'b1;
        $display("test async done");
        for (int lv = 1; lv >= 0; lv--)
        begin
            reset_level_select <= 1'(lv);
            @(posedge pclk);
            reset_in_n <= 1'b0;
            repeat (10) @(posedge pclk);
            set_all(lv ? ODAC_MID_SCALE : ODAC_ZERO_SCALE);
            check_all();
            apb(1'b0, ODAC_OFS_STATUS, 32'h0);
            `CHK(r, (32'(lv) << ODAC_STAT_LEVEL_BIT) | 32'h1)
            reset_level_select <= 1'(!lv);
            word(2, ODAC_CMD_WRITE_INPUT, 16'($urandom));
            pulse();
            check_all();
            apb(1'b0, ODAC_OFS_PENDING, 32'h0);
            `CHK(r, 32'h4)
            reset_in_n <= 1'b1;
            repeat (6) @(posedge pclk);
        end
        $display("test reset done");
        end_of_test();
    end
endmodule : testbench
